// ===== design/pcf_filter_ctrl.sv
// control, branch arithmetic and register readback of the compensation filter
// What this block does
// [R1] integral adder uses current sample alone at 0, current plus previous at 1 (reset).
// [R2] period product multiplies by switching period at 0, compensation constant at 1.
// [R3] duty multiplicand: 0 constant, 1 period, 2 feed-forward, 3 resonant duty.
// [R4] scale code: 0 none, 1..3 right shift, 4..7 left by 4,3,2,1.
// [R5] nonlinear table symmetry bit: 0 non-symmetric (reset), 1 symmetric.
// [R6] hold bits freeze derivative or integral branch output at its present value.
// [R7] proportional-off stops the proportional branch computing new outputs.
// [R8] derivative-off turns the branch off and clears its output to zero.
// [R9] integral-off halts the branch and clears its accumulated output to zero.
// [R10] writing force-start launches one calculation without a new converter sample.
// [R11] sample source: error converter at 0, software sample register at 1.
// [R12] filter runs only while enable is 1, its reset value.
// [R13] nine-bit software sample register, reset zero, replaces converter input.
// [R14] readback word: current sample low, previous sample at bit 16, zeros between.
// [R15] integral, derivative and final outputs readable as 24-bit signed words.
// [R16] busy reads 1 during a calculation, 0 while waiting for data.
// [R17] configuration is shadowed and copied to the filter only between samples.
// [R18] filter output is the sum of all three branches before scaling.
module pcf_filter_ctrl #(
  parameter int MULT_W = 18
) (
  input  wire logic                                   CLOCK,
  input  wire logic                                   RESET,
  input  wire logic [pcf_pkg::ADDR_W-1:0]             BUS_ADDR,
  input  wire logic [pcf_pkg::DATA_W-1:0]             BUS_WDATA,
  input  wire logic                                   BUS_WR,
  input  wire logic                                   BUS_RD,
  output logic [pcf_pkg::DATA_W-1:0]                  BUS_RDATA,
  input  wire logic [pcf_pkg::XN_W-1:0]               ADC_SAMPLE,
  input  wire logic                                   ADC_VALID,
  input  wire logic [pcf_pkg::COEF_W-1:0]             KP_COEF,
  input  wire logic [pcf_pkg::COEF_W-1:0]             KI_COEF,
  input  wire logic [pcf_pkg::COEF_W-1:0]             KD_COEF,
  input  wire logic [MULT_W-1:0]                      COMP_CONSTANT,
  input  wire logic [MULT_W-1:0]                      SWITCH_PERIOD,
  input  wire logic [MULT_W-1:0]                      FEED_FORWARD,
  input  wire logic [MULT_W-1:0]                      RESONANT_DUTY,
  output logic                                        NL_SYMMETRIC,
  output logic                                        FILTER_BUSY,
  output logic signed [pcf_pkg::Y_W+MULT_W:0]         DUTY_PRODUCT,
  output logic signed [pcf_pkg::Y_W+MULT_W:0]         PERIOD_PRODUCT,
  output logic                                        PRODUCT_VALID
);
  import pcf_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  logic [CTRL_W-1:0]      ctrl_q;
  logic [CTRL_W-1:0]      act_q;
  logic [XN_W-1:0]        swsamp_q;
  logic [DATA_W-1:0]      rdata_q;
  pcf_state_t             st_q;
  logic signed [XN_W-1:0] xn_q;
  logic signed [XN_W-1:0] xm1_q;
  logic signed [Y_W-1:0]  kp_q;
  logic signed [Y_W-1:0]  ki_q;
  logic signed [Y_W-1:0]  kd_q;
  logic signed [Y_W-1:0]  yn_q;
  logic                   valid_q;
  logic                   launch;
  logic                   busy;
  logic                   ctrl_wr;
  logic [XN_W-1:0]        sample_in;
  logic signed [COEF_W-1:0] kp_s;
  logic signed [COEF_W-1:0] ki_s;
  logic signed [COEF_W-1:0] kd_s;
  logic signed [XN_W:0]   isum;
  logic signed [XN_W:0]   ddiff;
  logic signed [47:0]     p_w;
  logic signed [47:0]     i_w;
  logic signed [47:0]     d_w;
  logic signed [47:0]     y_w;
  logic signed [47:0]     i_single;
  logic signed [Y_W-1:0]  yn_scaled;
  logic [MULT_W-1:0]      duty_m;
  logic [MULT_W-1:0]      per_m;
  logic [1:0]             dsel;

  // saturate a wide sum onto the 24-bit signed rails
  function automatic logic signed [Y_W-1:0] sat_y(input logic signed [47:0] v);
    if (v[47:Y_W-1] != {(48-Y_W+1){v[47]}})
      sat_y = v[47] ? {1'h1, {(Y_W-1){1'h0}}} : {1'h0, {(Y_W-1){1'h1}}};
    else
      sat_y = v[Y_W-1:0];
  endfunction : sat_y

  // ****************************************
  // register bus
  // ****************************************
  assign ctrl_wr = BUS_WR && (BUS_ADDR == CTRL_OFS);

  // force-start clears itself once the calculation is taken
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      ctrl_q <= CTRL_RESET;
    else if (ctrl_wr)
      ctrl_q <= BUS_WDATA[CTRL_W-1:0];
    else if (launch)
      ctrl_q[FORCE_BIT] <= 1'h0; // [R10]
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      swsamp_q <= SWSAMP_RESET;
    else if (BUS_WR && (BUS_ADDR == SWSAMP_OFS))
      swsamp_q <= BUS_WDATA[XN_W-1:0]; // [R13]
  end

  // read data stand for exactly one cycle, zero otherwise
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      rdata_q <= '0;
    else if (!BUS_RD)
      rdata_q <= '0;
    else if (BUS_ADDR == STATUS_OFS)
      rdata_q <= DATA_W'({busy, 4'h0}); // [R16]
    else if (BUS_ADDR == CTRL_OFS)
      rdata_q <= DATA_W'(ctrl_q);
    else if (BUS_ADDR == SWSAMP_OFS)
      rdata_q <= DATA_W'(swsamp_q);
    else if (BUS_ADDR == XNREAD_OFS)
      rdata_q <= DATA_W'({xm1_q, 7'h00, xn_q}); // [R14]
    else if (BUS_ADDR == KIREAD_OFS)
      rdata_q <= DATA_W'($unsigned(ki_q)); // [R15]
    else if (BUS_ADDR == KDREAD_OFS)
      rdata_q <= DATA_W'($unsigned(kd_q)); // [R15]
    else if (BUS_ADDR == YNREAD_OFS)
      rdata_q <= DATA_W'($unsigned(yn_q)); // [R15]
    else
      rdata_q <= '0;
  end

  assign BUS_RDATA = rdata_q;

  // ****************************************
  // shadowed configuration
  // ****************************************
  // copying only in idle keeps one sample on one consistent setting
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      act_q <= CTRL_RESET;
    else if (st_q == ST_IDLE)
      act_q <= ctrl_q; // [R17]
  end

  assign NL_SYMMETRIC = act_q[NL_SYM_BIT]; // [R5]

  // ****************************************
  // sequencing
  // ****************************************
  // in software-sample mode only force-start launches; converter strobes are ignored
  assign launch = (st_q == ST_IDLE) && act_q[EN_BIT] && // [R12]
                  (ctrl_q[FORCE_BIT] || (ADC_VALID && !act_q[CPU_SRC_BIT])); // [R10]
  assign busy        = (st_q != ST_IDLE); // [R16]
  assign FILTER_BUSY = busy;

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      st_q <= ST_IDLE;
    else
    begin
      case (st_q)
        ST_IDLE:   st_q <= launch ? ST_BRANCH : ST_IDLE;
        ST_BRANCH: st_q <= ST_SUM;
        ST_SUM:    st_q <= ST_MULT;
        default:   st_q <= ST_IDLE;
      endcase
    end
  end

  assign sample_in = act_q[CPU_SRC_BIT] ? swsamp_q : ADC_SAMPLE; // [R11]

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
    begin
      xn_q  <= '0;
      xm1_q <= '0;
    end
    else if (launch)
    begin
      xn_q  <= sample_in;
      xm1_q <= xn_q; // [R14]
    end
  end

  // ****************************************
  // branch arithmetic
  // ****************************************
  assign kp_s  = KP_COEF;
  assign ki_s  = KI_COEF;
  assign kd_s  = KD_COEF;
  assign isum  = act_q[ADDER_BIT] ? (xn_q + xm1_q) : (XN_W+1)'(xn_q); // [R1]
  assign ddiff = xn_q - xm1_q;
  assign p_w   = kp_s * xn_q;
  assign i_w   = ki_s * isum + ki_q;
  assign d_w   = kd_s * ddiff;
  assign y_w   = kp_q + ki_q + kd_q; // [R18]

  // proportional-off keeps the last value instead of zeroing it
  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      kp_q <= '0;
    else if ((st_q == ST_BRANCH) && !act_q[PROPORTIONAL_DISABLE_BIT]) // [R7]
      kp_q <= sat_y(p_w);
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      ki_q <= '0;
    else if (act_q[INTEGRAL_DISABLE_BIT])
      ki_q <= '0; // [R9]
    else if ((st_q == ST_BRANCH) && !act_q[KI_HOLD_BIT]) // [R6]
      ki_q <= sat_y(i_w);
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      kd_q <= '0;
    else if (act_q[DERIVATIVE_DISABLE_BIT])
      kd_q <= '0; // [R8]
    else if ((st_q == ST_BRANCH) && !act_q[KD_HOLD_BIT]) // [R6]
      kd_q <= sat_y(d_w);
  end

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      yn_q <= '0;
    else if (st_q == ST_SUM)
      yn_q <= sat_y(y_w); // [R18]
  end

  // ****************************************
  // output scaling and multiplicands
  // ****************************************
  pcf_scaler #(
    .W      (Y_W)
  ) u_scaler (
    .y      (yn_q),
    .code   (act_q[SCALE_LSB+2:SCALE_LSB]), // [R4]
    .scaled (yn_scaled)
  );

  assign dsel = act_q[DUTY_SEL_LSB+1:DUTY_SEL_LSB];

  always_comb
  begin
    case (pcf_dsel_t'(dsel)) // [R3]
      DSEL_PERIOD: duty_m = SWITCH_PERIOD;
      DSEL_FFWD:   duty_m = FEED_FORWARD;
      DSEL_RES:    duty_m = RESONANT_DUTY;
      default:     duty_m = COMP_CONSTANT;
    endcase
  end

  assign per_m = act_q[PER_SEL_BIT] ? COMP_CONSTANT : SWITCH_PERIOD; // [R2]

  pcf_mult #(
    .YW     (Y_W),
    .MW     (MULT_W)
  ) u_duty_mult (
    .clk    (CLOCK),
    .rst    (RESET),
    .load   (st_q == ST_MULT),
    .y      (yn_scaled),
    .m      (duty_m),
    .prod_q (DUTY_PRODUCT)
  );

  pcf_mult #(
    .YW     (Y_W),
    .MW     (MULT_W)
  ) u_per_mult (
    .clk    (CLOCK),
    .rst    (RESET),
    .load   (st_q == ST_MULT),
    .y      (yn_scaled),
    .m      (per_m),
    .prod_q (PERIOD_PRODUCT)
  );

  always_ff @(posedge CLOCK)
  begin
    if (RESET)
      valid_q <= 1'h0;
    else
      valid_q <= (st_q == ST_MULT);
  end

  assign PRODUCT_VALID = valid_q;

  // ****************************************
  // assertions
  // ****************************************
  // integral step with the current sample alone, for the adder check
  assign i_single = ki_s * xn_q + ki_q;

  sequence s_run;
    busy [*3] ##1 (!busy && PRODUCT_VALID);
  endsequence

  sequence s_idle_stay;
    (st_q == ST_IDLE) [*2];
  endsequence

  AST_INTEGRAL_DISABLE_CLEARS: assert property (@(posedge CLOCK) disable iff (RESET) // [R9]
    act_q[INTEGRAL_DISABLE_BIT] |=> (ki_q == '0))
    else $error("integral output not cleared while off");

  AST_DERIVATIVE_DISABLE_CLEARS: assert property (@(posedge CLOCK) disable iff (RESET) // [R8]
    act_q[DERIVATIVE_DISABLE_BIT] |=> (kd_q == '0))
    else $error("derivative output not cleared while off");

  AST_KI_HOLD: assert property (@(posedge CLOCK) disable iff (RESET) // [R6]
    (act_q[KI_HOLD_BIT] && !act_q[INTEGRAL_DISABLE_BIT]) |=> $stable(ki_q))
    else $error("integral output moved while held");

  AST_KD_HOLD: assert property (@(posedge CLOCK) disable iff (RESET) // [R6]
    (act_q[KD_HOLD_BIT] && !act_q[DERIVATIVE_DISABLE_BIT]) |=> $stable(kd_q))
    else $error("derivative output moved while held");

  AST_PROPORTIONAL_DISABLE: assert property (@(posedge CLOCK) disable iff (RESET) // [R7]
    act_q[PROPORTIONAL_DISABLE_BIT] |=> $stable(kp_q))
    else $error("proportional output moved while off");

  AST_DISABLED_IDLE: assert property (@(posedge CLOCK) disable iff (RESET) // [R12]
    ((st_q == ST_IDLE) && !act_q[EN_BIT]) |=> (st_q == ST_IDLE))
    else $error("calculation started while disabled");

  AST_FORCE_RUN: assert property (@(posedge CLOCK) disable iff (RESET) // [R10]
    ((st_q == ST_IDLE) && act_q[EN_BIT] && ctrl_q[FORCE_BIT]) |=> s_run)
    else $error("force start did not run one calculation");

  AST_BUSY_SPAN: assert property (@(posedge CLOCK) disable iff (RESET) // [R16]
    launch |=> s_run)
    else $error("busy did not span exactly three cycles");

  AST_NO_TRIGGER: assert property (@(posedge CLOCK) disable iff (RESET) // [R10]
    ((st_q == ST_IDLE) && !ctrl_q[FORCE_BIT] && (act_q[CPU_SRC_BIT] || !ADC_VALID))
    |=> (st_q == ST_IDLE))
    else $error("calculation started without a trigger");

  AST_CPU_SOURCE: assert property (@(posedge CLOCK) disable iff (RESET) // [R11]
    (launch && act_q[CPU_SRC_BIT]) |=> (xn_q == $past(swsamp_q)))
    else $error("software sample not taken");

  AST_ADC_SOURCE: assert property (@(posedge CLOCK) disable iff (RESET) // [R11]
    (launch && !act_q[CPU_SRC_BIT]) |=> (xn_q == $past(ADC_SAMPLE)))
    else $error("converter sample not taken");

  AST_SAMPLE_SHIFT: assert property (@(posedge CLOCK) disable iff (RESET) // [R14]
    launch |=> (xm1_q == $past(xn_q)))
    else $error("previous sample not shifted");

  AST_SHADOW: assert property (@(posedge CLOCK) disable iff (RESET) // [R17]
    busy |=> $stable(act_q))
    else $error("active configuration changed mid calculation");

  AST_SUM: assert property (@(posedge CLOCK) disable iff (RESET) // [R18]
    (st_q == ST_SUM) |=> (yn_q == sat_y($past(y_w))))
    else $error("filter output not the branch sum");

  AST_ADDER_SINGLE: assert property (@(posedge CLOCK) disable iff (RESET) // [R1]
    ((st_q == ST_BRANCH) && !act_q[ADDER_BIT] && !act_q[KI_HOLD_BIT]
      && !act_q[INTEGRAL_DISABLE_BIT]) |=> (ki_q == sat_y($past(i_single))))
    else $error("integral adder used previous sample");

  AST_IDLE_QUIET: assert property (@(posedge CLOCK) disable iff (RESET) // [R16]
    s_idle_stay |-> !PRODUCT_VALID)
    else $error("product valid without a calculation");

endmodule : pcf_filter_ctrl

// ===== design/pcf_mult.sv
// registered product of scaled filter output and an unsigned multiplicand
module pcf_mult #(
  parameter int YW = 24,
  parameter int MW = 18
) (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire logic                      load,
  input  wire logic signed [YW-1:0]      y,
  input  wire logic [MW-1:0]             m,
  output logic signed [YW+MW:0]          prod_q
);
  logic signed [MW:0]    m_s;
  logic signed [YW+MW:0] prod_d;

  assign m_s    = $signed({1'h0, m});
  assign prod_d = y * m_s;

  always_ff @(posedge clk)
  begin
    if (rst)
      prod_q <= '0;
    else if (load)
      prod_q <= prod_d;
  end
endmodule : pcf_mult

// ===== design/pcf_scaler.sv
// output scaling shifter of the compensation filter
module pcf_scaler #(
  parameter int W = 24
) (
  input  wire logic signed [W-1:0] y,
  input  wire logic [2:0]          code,
  output logic signed [W-1:0]      scaled
);
  // left shifts wrap; coefficients are expected to leave headroom
  always_comb
  begin
    case (code)
      3'h1:    scaled = y >>> 1;
      3'h2:    scaled = y >>> 2;
      3'h3:    scaled = y >>> 3;
      3'h4:    scaled = y <<< 4;
      3'h5:    scaled = y <<< 3;
      3'h6:    scaled = y <<< 2;
      3'h7:    scaled = y <<< 1;
      default: scaled = y;
    endcase
  end
endmodule : pcf_scaler

// ===== shared/pcf_pkg.sv
// shared constants, register map and types of the compensation filter control block
package pcf_pkg;

  // ****************************************
  // widths
  // ****************************************
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int XN_W   = 9;
  localparam int Y_W    = 24;
  localparam int COEF_W = 16;
  localparam int CTRL_W = 16;

  // ****************************************
  // register byte addresses
  // ****************************************
  localparam logic [ADDR_W-1:0] STATUS_OFS  = 32'h001C0000;
  localparam logic [ADDR_W-1:0] CTRL_OFS    = 32'h001C0004;
  localparam logic [ADDR_W-1:0] SWSAMP_OFS  = 32'h001C0008;
  localparam logic [ADDR_W-1:0] XNREAD_OFS  = 32'h001C000C;
  localparam logic [ADDR_W-1:0] KIREAD_OFS  = 32'h001C0010;
  localparam logic [ADDR_W-1:0] KDREAD_OFS  = 32'h001C0014;
  localparam logic [ADDR_W-1:0] YNREAD_OFS  = 32'h001C0018;

  // ****************************************
  // field positions and reset values
  // ****************************************
  localparam int EN_BIT        = 0;
  localparam int CPU_SRC_BIT   = 1;
  localparam int FORCE_BIT     = 2;
  localparam int INTEGRAL_DISABLE_BIT    = 3;
  localparam int DERIVATIVE_DISABLE_BIT    = 4;
  localparam int PROPORTIONAL_DISABLE_BIT    = 5;
  localparam int KI_HOLD_BIT   = 6;
  localparam int KD_HOLD_BIT   = 7;
  localparam int NL_SYM_BIT    = 8;
  localparam int SCALE_LSB     = 9;
  localparam int DUTY_SEL_LSB  = 12;
  localparam int PER_SEL_BIT   = 14;
  localparam int ADDER_BIT     = 15;
  localparam int XNM1_LSB      = 16;
  localparam int BUSY_BIT      = 4;
  localparam logic [CTRL_W-1:0] CTRL_RESET   = 16'h8001;
  localparam logic [XN_W-1:0]   SWSAMP_RESET = 9'h000;

  typedef enum logic [1:0] {DSEL_COMP, DSEL_PERIOD, DSEL_FFWD, DSEL_RES} pcf_dsel_t;
  typedef enum {ST_IDLE, ST_BRANCH, ST_SUM, ST_MULT} pcf_state_t;

endpackage : pcf_pkg

// ===== sim/pcf_adc_model.sv
// error converter model: one-cycle sample pulse on request
module pcf_adc_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       fire,
  input  wire logic [8:0] value,
  output logic      [8:0] sample,
  output logic            valid
);
  timeunit 1ns;
  timeprecision 1ps;
  // sample line is not held past the pulse, so it keeps changing
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      valid  <= 1'b0;
      sample <= 9'h000;
    end
    else
    begin
      valid  <= fire;
      sample <= fire ? value : ~sample;
    end
  end
endmodule : pcf_adc_model

// ===== sim/tb_top.sv
// self-checking bench of the compensation filter control block
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import pcf_pkg::*;
  // ****************
  // signals
  // ****************
  localparam logic [31:0] C_EN  = 32'h1 << EN_BIT;
  localparam logic [31:0] C_SRC = 32'h1 << CPU_SRC_BIT;
  localparam logic [31:0] C_FRC = 32'h1 << FORCE_BIT;
  localparam logic [31:0] C_KIO = 32'h1 << INTEGRAL_DISABLE_BIT;
  localparam logic [31:0] C_KDO = 32'h1 << DERIVATIVE_DISABLE_BIT;
  localparam logic [31:0] C_KPO = 32'h1 << PROPORTIONAL_DISABLE_BIT;
  localparam logic [31:0] C_KIH = 32'h1 << KI_HOLD_BIT;
  localparam logic [31:0] C_KDH = 32'h1 << KD_HOLD_BIT;
  localparam logic [31:0] C_NL  = 32'h1 << NL_SYM_BIT;
  localparam logic [31:0] C_ADD = 32'h1 << ADDER_BIT;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic [31:0] addr = '0;
  logic [31:0] wdata = '0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic [31:0] rdata;
  logic [8:0]  adc_s;
  logic        adc_v;
  logic        fire = 1'b0;
  logic [8:0]  fval = '0;
  logic [15:0] kp = '0;
  logic [15:0] ki = '0;
  logic [15:0] kd = '0;
  logic [17:0] mlt [4] = '{18'h00003, 18'h00005, 18'h00007, 18'h20001};
  logic        nl;
  logic        busy;
  logic        pv;
  logic signed [42:0] duty;
  logic signed [42:0] per;
  logic [31:0] r;
  int          n_fail = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  int          n_valid = 0;

  always #4 clk = ~clk;

  pcf_adc_model adc_m (.clk(clk), .rst(rst), .fire(fire), .value(fval), .sample(adc_s),
    .valid(adc_v));

  pcf_filter_ctrl #(.MULT_W(18)) uut (.CLOCK(clk), .RESET(rst), .BUS_ADDR(addr),
    .BUS_WDATA(wdata), .BUS_WR(wr), .BUS_RD(rd), .BUS_RDATA(rdata), .ADC_SAMPLE(adc_s),
    .ADC_VALID(adc_v), .KP_COEF(kp), .KI_COEF(ki), .KD_COEF(kd), .COMP_CONSTANT(mlt[0]),
    .SWITCH_PERIOD(mlt[1]), .FEED_FORWARD(mlt[2]), .RESONANT_DUTY(mlt[3]),
    .NL_SYMMETRIC(nl), .FILTER_BUSY(busy), .DUTY_PRODUCT(duty), .PERIOD_PRODUCT(per),
    .PRODUCT_VALID(pv));

  // ****************
  // shared tasks
  // ****************
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wr32(input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr32

  // read data stand only in the cycle after the strobe
  task automatic rd32(input logic [31:0] a, output logic [31:0] d);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd32

  // config first, force second: launch gating sees the active copy
  task automatic go(input logic [31:0] cfg);
    int lat;
    lat = 0;
    wr32(CTRL_OFS, cfg);
    wr32(CTRL_OFS, cfg | C_FRC);
    while (pv !== 1'b1 && lat < 20)
    begin
      @(posedge clk);
      #1;
      lat++;
    end
    chk("force run", 64'(lat < 20), 64'h1);
  endtask : go

  task automatic adc(input logic [8:0] v);
    @(posedge clk);
    fire <= 1'b1;
    fval <= v;
    @(posedge clk);
    fire <= 1'b0;
  endtask : adc

  task automatic rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    rd32(a, r);
    chk(what, 64'(r), 64'(exp));
  endtask : rchk

  // ****************
  // scenarios
  // ****************
  task automatic t_reset();
    chk("nl", 64'(nl), 64'h0);
    chk("busy", 64'(busy), 64'h0);
    rchk("ctrl", CTRL_OFS, 32'h00008001);
    rchk("swsamp", SWSAMP_OFS, 32'h0);
    rchk("status", STATUS_OFS, 32'h0);
    wr32(32'h001C0020, 32'hFFFFFFFF);
    rchk("unmapped", 32'h001C0020, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_soft();
    @(posedge clk);
    ki <= 16'h0002;
    kd <= 16'h0001;
    wr32(SWSAMP_OFS, 32'h3);
    rchk("swsamp", SWSAMP_OFS, 32'h3);
    go(C_EN | C_SRC | C_ADD);
    rchk("xn", XNREAD_OFS, 32'h00000003);
    rchk("ki", KIREAD_OFS, 32'h6);
    rchk("kd", KDREAD_OFS, 32'h3);
    rchk("yn", YNREAD_OFS, 32'h9);
    chk("duty", 64'(duty), 64'(9 * 3));
    chk("period", 64'(per), 64'(9 * 5));
    wr32(SWSAMP_OFS, 32'h1FE);
    go(C_EN | C_SRC);
    rchk("ki", KIREAD_OFS, 32'h2);
    rchk("kd", KDREAD_OFS, 32'h00FFFFFB);
    rchk("yn", YNREAD_OFS, 32'h00FFFFFD);
    wr32(XNREAD_OFS, 32'hFFFFFFFF);
    rchk("xn", XNREAD_OFS, 32'h000301FE);
    rchk("ctrl", CTRL_OFS, C_EN | C_SRC);
    repeat (8) @(posedge clk);
    chk("idle", 64'(n_valid), 64'h2);
    $display("test software sample done");
  endtask : t_soft

  task automatic t_select();
    longint sc;
    @(posedge clk);
    kp <= 16'h0001;
    wr32(SWSAMP_OFS, 32'h8);
    for (int i = 0; i < 8; i++)
    begin
      sc = (i < 4) ? (8 >> i) : (8 << (8 - i));
      go(C_EN | C_SRC | C_KIO | C_KDO | (32'(i) << SCALE_LSB)
        | (32'(i % 4) << DUTY_SEL_LSB) | (32'(i % 2) << PER_SEL_BIT));
      chk("duty", 64'(duty), 64'(sc * longint'(mlt[i % 4])));
      chk("period", 64'(per), 64'(sc * longint'(mlt[(i % 2) ? 0 : 1])));
    end
    rchk("integral_disable", KIREAD_OFS, 32'h0);
    rchk("derivative_disable", KDREAD_OFS, 32'h0);
    $display("test selects done");
  endtask : t_select

  task automatic t_hold();
    @(posedge clk);
    ki <= 16'h0001;
    go(C_EN | C_SRC | C_ADD);
    rchk("yn", YNREAD_OFS, 32'h18);
    wr32(SWSAMP_OFS, 32'h4);
    go(C_EN | C_SRC | C_ADD | C_KIH | C_KDH | C_KPO);
    rchk("ki hold", KIREAD_OFS, 32'h10);
    rchk("kd hold", KDREAD_OFS, 32'h0);
    rchk("proportional_disable", YNREAD_OFS, 32'h18);
    $display("test holds done");
  endtask : t_hold

  task automatic t_adc();
    int nv;
    wr32(CTRL_OFS, C_EN | C_SRC);
    nv = n_valid;
    adc(9'h055);
    repeat (8) @(posedge clk);
    chk("sw mode drop", 64'(n_valid), 64'(nv));
    wr32(CTRL_OFS, 32'h0);
    adc(9'h066);
    repeat (8) @(posedge clk);
    chk("disabled", 64'(n_valid), 64'(nv));
    wr32(CTRL_OFS, C_EN);
    rchk("status", STATUS_OFS, 32'h0);
    adc(9'h005);
    @(posedge clk);
    #1;
    chk("busy c1", 64'(busy), 64'h1);
    repeat (2) @(posedge clk);
    #1;
    chk("valid c3", 64'(pv), 64'h0);
    @(posedge clk);
    #1;
    chk("valid c4", 64'(pv), 64'h1);
    chk("busy c4", 64'(busy), 64'h0);
    rchk("xn", XNREAD_OFS, 32'h00040005);
    $display("test converter path done");
  endtask : t_adc

  task automatic t_shadow();
    wr32(CTRL_OFS, C_EN | C_NL);
    @(posedge clk);
    #1;
    chk("nl set", 64'(nl), 64'h1);
    adc(9'h010);
    wr32(CTRL_OFS, C_EN);
    #1;
    chk("nl busy", 64'(nl), 64'h1);
    @(posedge clk);
    #1;
    chk("nl busy", 64'(nl), 64'h1);
    repeat (3) @(posedge clk);
    #1;
    chk("nl clear", 64'(nl), 64'h0);
    $display("test shadow done");
  endtask : t_shadow

  task automatic results();
    $display("compares %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : results

  always @(posedge clk)
  begin
    if (pv === 1'b1)
      n_valid++;
    cyc++;
    // a few hundred cycles are needed; far beyond means a hang
    if (cyc == 5000)
    begin
      n_fail++;
      results();
    end
  end

  initial
  begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_soft();
    t_select();
    t_hold();
    t_adc();
    t_shadow();
    results();
  end
endmodule : tb_top
